/* File: verilog/sac_pkg.sv */
/*
 * Constants, register map and types of the host-side controller for a
 * 12-bit successive-approximation converter with a parallel result bus.
 * Assumes a 50 MHz system clock and APB access to the controller registers.
 */
`default_nettype none
package sac_pkg;
    localparam int unsigned SYS_PERIOD_NS = 20;
    localparam int unsigned CONV_CLK_MAX_KHZ = 6000;
    localparam int unsigned ACQ_NS = 350;
    localparam int unsigned ACCESS_NS = 75;
    localparam int unsigned SYNC_STAGES = 3;
    // half period of the conversion clock, rounded up so the rate stays low
    localparam logic [3:0] CLK_HALF = 4'((1000000 + 2 * SYS_PERIOD_NS *
        CONV_CLK_MAX_KHZ - 1) / (2 * SYS_PERIOD_NS * CONV_CLK_MAX_KHZ));
    localparam logic [7:0] ACQ_CYC = 8'((ACQ_NS + SYS_PERIOD_NS - 1) /
        SYS_PERIOD_NS);
    localparam logic [7:0] RD_HOLD = 8'((ACCESS_NS + SYS_PERIOD_NS - 1) /
        SYS_PERIOD_NS + SYNC_STAGES);
    localparam logic [7:0] PWR_CLKS = 8'h0E;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;
    localparam int unsigned CTRL_INT_BIT = 3;
    localparam int unsigned CTRL_RUN_BIT = 4;
    localparam int unsigned CMD_START_BIT = 0;
    localparam int unsigned CMD_READ_BIT = 1;
    typedef enum logic [2:0] {
        MODE_FULL = 3'h0,
        MODE_STAND = 3'h1,
        MODE_SLOW = 3'h2,
        MODE_ROM = 3'h3,
        MODE_CONT = 3'h4
    } sac_mode_t;
    localparam sac_mode_t CTRL_MODE_RST = MODE_FULL;
    typedef enum logic [2:0] {
        ST_WAITCLK = 3'h0,
        ST_ACQ = 3'h1,
        ST_IDLE = 3'h2,
        ST_CONV = 3'h3,
        ST_CAP = 3'h4,
        ST_CONT = 3'h5
    } sac_state_t;
endpackage : sac_pkg
`default_nettype wire

/* File: verilog/sac_ctrl.sv */
/*
 * Host-side controller for a 12-bit successive-approximation converter:
 * makes the conversion clock, drives the start, read and select strobes,
 * samples the status pin and the result bus. Software reaches it over APB.
 * Assumes the converter pins are asynchronous to clk_sys_i.
 */
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    output logic conv_clk_o,
    output logic convert_start_n_o,
    output logic rd_n_o,
    output logic cs_n_o,
    input wire logic status_n_i,
    input wire logic [11:0] result_bus_i
);
    logic rst_m, rst_n;
    logic [3:0] div_cnt, next_div_cnt;
    logic next_conv_clk, clk_rise, clk_fall;
    logic [12:0] sync_1, sync_2, sync_3, pin_q, next_pin_q;
    logic stat_q;
    logic next_pready, next_slverr;
    logic [31:0] next_prdata;
    sac_pkg::sac_mode_t mode, next_mode;
    logic int_pol, next_int_pol, run, next_run;
    logic apb_done, wr_cmd, rd_res;
    sac_pkg::sac_state_t state, next_state;
    logic [7:0] cnt, next_cnt;
    logic next_cv_n, next_rd_n, next_cs_n;
    logic seen_low, next_seen, rd_flag, next_rd_flag;
    logic ready, next_ready, valid, next_valid;
    logic pend_start, next_pend_start, pend_read, next_pend_read;
    logic take, cap_now;
    logic [11:0] result, next_result;

    // reset release through two flops
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    always_comb begin
        next_div_cnt = div_cnt + 4'h1;
        next_conv_clk = conv_clk_o;
        if (div_cnt == sac_pkg::CLK_HALF - 4'h1) begin
            next_div_cnt = 4'h0;
            next_conv_clk = !conv_clk_o;
        end
    end
    assign clk_rise = (div_cnt == sac_pkg::CLK_HALF - 4'h1) && !conv_clk_o;
    assign clk_fall = (div_cnt == sac_pkg::CLK_HALF - 4'h1) && conv_clk_o;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 4'h0;
            conv_clk_o <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            conv_clk_o <= next_conv_clk;
        end
    end

    // status and bus pass three flops; a value counts once stages agree
    always_comb begin
        next_pin_q = pin_q;
        if (sync_2 == sync_3) begin
            next_pin_q = sync_3;
        end
    end
    assign stat_q = pin_q[12];

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_1 <= 13'h1000;
            sync_2 <= 13'h1000;
            sync_3 <= 13'h1000;
            pin_q <= 13'h1000;
        end else begin
            sync_1 <= {status_n_i, result_bus_i};
            sync_2 <= sync_1;
            sync_3 <= sync_2;
            pin_q <= next_pin_q;
        end
    end

    // apb slave: one wait state, answer registered
    assign apb_done = psel_i && penable_i && pready_o;
    assign wr_cmd = apb_done && pwrite_i && (paddr_i == sac_pkg::REG_CMD);
    assign rd_res = apb_done && !pwrite_i && (paddr_i == sac_pkg::REG_RESULT);

    always_comb begin
        next_pready = psel_i && penable_i && !pready_o;
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        next_mode = mode;
        next_int_pol = int_pol;
        next_run = run;
        if (psel_i && penable_i && !pready_o) begin
            case (paddr_i)
                sac_pkg::REG_CTRL: next_prdata = {27'h0, run, int_pol, mode};
                sac_pkg::REG_CMD: next_prdata = 32'h0000_0000;
                sac_pkg::REG_STATUS:
                    next_prdata = {28'h0, stat_q, valid, ready,
                        state != sac_pkg::ST_IDLE};
                sac_pkg::REG_RESULT: next_prdata = {20'h0, result};
                default: next_slverr = 1'b1;
            endcase
        end
        if (apb_done && pwrite_i && (paddr_i == sac_pkg::REG_CTRL)) begin
            next_mode = sac_pkg::sac_mode_t'(pwdata_i[2:0]);
            next_int_pol = pwdata_i[sac_pkg::CTRL_INT_BIT];
            next_run = pwdata_i[sac_pkg::CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            mode <= sac_pkg::CTRL_MODE_RST;
            int_pol <= 1'b0;
            run <= 1'b0;
        end else begin
            pready_o <= next_pready;
            pslverr_o <= next_slverr;
            prdata_o <= next_prdata;
            mode <= next_mode;
            int_pol <= next_int_pol;
            run <= next_run;
        end
    end

    // conversion sequencer
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cv_n = convert_start_n_o;
        next_rd_n = rd_n_o;
        next_cs_n = cs_n_o;
        next_seen = seen_low;
        next_rd_flag = rd_flag;
        next_ready = ready;
        take = 1'b0;
        cap_now = 1'b0;
        unique case (state)
            sac_pkg::ST_WAITCLK: begin
                if (clk_rise) begin
                    next_cnt = cnt + 8'h01;
                    if (cnt == sac_pkg::PWR_CLKS - 8'h01) begin
                        next_cnt = 8'h00;
                        next_state = sac_pkg::ST_ACQ;
                    end
                end
            end
            sac_pkg::ST_ACQ: begin
                next_cnt = cnt + 8'h01;
                if (cnt == sac_pkg::ACQ_CYC - 8'h01) begin
                    next_cnt = 8'h00;
                    next_ready = 1'b1;
                    next_state = sac_pkg::ST_IDLE;
                end
            end
            sac_pkg::ST_IDLE: begin
                next_cnt = 8'h00;
                next_seen = 1'b0;
                // every start lands on a falling conversion clock edge
                if (clk_fall) begin
                    // idle levels stand in for grounded pins; moved only
                    // here since a falling convert-start starts the device
                    next_rd_n = (mode != sac_pkg::MODE_STAND);
                    next_cs_n = (mode != sac_pkg::MODE_STAND);
                    next_cv_n = !(mode == sac_pkg::MODE_SLOW ||
                        mode == sac_pkg::MODE_ROM);
                    unique case (mode)
                        sac_pkg::MODE_FULL: begin
                            if (pend_start) begin
                                take = 1'b1;
                                next_cv_n = 1'b0;
                                next_rd_n = !pend_read;
                                next_cs_n = !pend_read;
                                next_rd_flag = pend_read;
                                next_state = sac_pkg::ST_CONV;
                            end else if (pend_read) begin
                                take = 1'b1;
                                next_rd_n = 1'b0;
                                next_cs_n = 1'b0;
                                next_state = sac_pkg::ST_CAP;
                            end
                        end
                        sac_pkg::MODE_STAND: begin
                            if (pend_start) begin
                                take = 1'b1;
                                next_cv_n = 1'b0;
                                next_state = sac_pkg::ST_CONV;
                            end
                        end
                        sac_pkg::MODE_SLOW: begin
                            if (pend_start || pend_read) begin
                                take = 1'b1;
                                next_rd_n = 1'b0;
                                next_cs_n = 1'b0;
                                next_state = sac_pkg::ST_CONV;
                            end
                        end
                        sac_pkg::MODE_ROM: begin
                            if (pend_start || pend_read) begin
                                take = 1'b1;
                                next_rd_n = 1'b0;
                                next_cs_n = 1'b0;
                                next_state = sac_pkg::ST_CAP;
                            end
                        end
                        sac_pkg::MODE_CONT: begin
                            if (run) begin
                                next_cv_n = 1'b0;
                                next_rd_n = 1'b0;
                                next_cs_n = 1'b0;
                                next_state = sac_pkg::ST_CONT;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            sac_pkg::ST_CONV: begin
                // a low status is noted at once; the end is not taken before cnt reaches RD_HOLD
                if (!stat_q) begin
                    next_seen = 1'b1;
                end
                if (cnt != sac_pkg::RD_HOLD) begin
                    next_cnt = cnt + 8'h01;
                end
                if (cnt == sac_pkg::RD_HOLD - 8'h01) begin
                    if (mode != sac_pkg::MODE_SLOW) begin
                        next_cv_n = 1'b1;
                    end
                    if (rd_flag) begin
                        cap_now = 1'b1;
                        next_rd_n = 1'b1;
                        next_cs_n = 1'b1;
                        next_rd_flag = 1'b0;
                    end
                end else if (cnt == sac_pkg::RD_HOLD &&
                    (int_pol ? !stat_q : (seen_low && stat_q))) begin
                    next_cnt = 8'h00;
                    next_seen = 1'b0;
                    next_state = (mode == sac_pkg::MODE_FULL) ?
                        sac_pkg::ST_ACQ : sac_pkg::ST_CAP;
                end
            end
            sac_pkg::ST_CAP: begin
                next_cnt = cnt + 8'h01;
                if (cnt == sac_pkg::RD_HOLD - 8'h01) begin
                    cap_now = 1'b1;
                    next_cnt = 8'h00;
                    next_rd_n = (mode != sac_pkg::MODE_STAND);
                    next_cs_n = (mode != sac_pkg::MODE_STAND);
                    next_state = (mode == sac_pkg::MODE_ROM) ?
                        sac_pkg::ST_WAITCLK : sac_pkg::ST_ACQ;
                end
            end
            sac_pkg::ST_CONT: begin
                if (!run || mode != sac_pkg::MODE_CONT) begin
                    next_cv_n = 1'b1;
                    next_rd_n = 1'b1;
                    next_cs_n = 1'b1;
                    next_cnt = 8'h00;
                    next_state = sac_pkg::ST_ACQ;
                end else begin
                    if (cnt == sac_pkg::RD_HOLD) begin
                        cap_now = 1'b1;
                        next_cnt = 8'h00;
                    end else if (cnt != 8'h00) begin
                        next_cnt = cnt + 8'h01;
                    end
                    if (!stat_q) begin
                        next_seen = 1'b1;
                    end
                    if (seen_low && stat_q) begin
                        next_seen = 1'b0;
                        next_cnt = 8'h01;
                    end
                end
            end
            default: next_state = sac_pkg::ST_ACQ;
        endcase
        next_result = cap_now ? pin_q[11:0] : result;
        // a capture in the same cycle as a result read keeps valid set
        next_valid = cap_now ? 1'b1 : (rd_res ? 1'b0 : valid);
        next_pend_start = (take ? 1'b0 : pend_start) ||
            (wr_cmd && pwdata_i[sac_pkg::CMD_START_BIT]);
        next_pend_read = (take ? 1'b0 : pend_read) ||
            (wr_cmd && pwdata_i[sac_pkg::CMD_READ_BIT]);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= sac_pkg::ST_WAITCLK;
            cnt <= 8'h00;
            convert_start_n_o <= 1'b1;
            rd_n_o <= 1'b1;
            cs_n_o <= 1'b1;
            seen_low <= 1'b0;
            rd_flag <= 1'b0;
            ready <= 1'b0;
            valid <= 1'b0;
            pend_start <= 1'b0;
            pend_read <= 1'b0;
            result <= 12'h000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            convert_start_n_o <= next_cv_n;
            rd_n_o <= next_rd_n;
            cs_n_o <= next_cs_n;
            seen_low <= next_seen;
            rd_flag <= next_rd_flag;
            ready <= next_ready;
            valid <= next_valid;
            pend_start <= next_pend_start;
            pend_read <= next_pend_read;
            result <= next_result;
        end
    end

    // helper counters read only by the checks below
    logic [7:0] gap_cnt;
    logic [8:0] since_rst;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt <= 8'h00;
            since_rst <= 9'h000;
        end else begin
            gap_cnt <= (state == sac_pkg::ST_CONV && next_state !=
                sac_pkg::ST_CONV) ? 8'h00 :
                (gap_cnt == 8'hFF ? gap_cnt : gap_cnt + 8'h01);
            since_rst <= (since_rst == 9'h1FF) ? since_rst : since_rst + 9'h001;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n);

    chk_clk_half: assert property ($changed(conv_clk_o) |=>
        $stable(conv_clk_o)[*4]) else $error("conversion clock too fast");
    chk_start_edge: assert property ($fell(convert_start_n_o) |->
        $fell(conv_clk_o)) else $error("start not on clock fall");
    chk_no_restart: assert property ($fell(convert_start_n_o) |->
        $past(state) == sac_pkg::ST_IDLE) else $error("start during conversion");
    chk_read_only: assert property (mode == sac_pkg::MODE_FULL &&
        state == sac_pkg::ST_CAP |-> convert_start_n_o)
        else $error("read-only pulled start low");
    chk_start_only: assert property (mode == sac_pkg::MODE_FULL &&
        state == sac_pkg::ST_CONV && !rd_flag |-> rd_n_o && cs_n_o)
        else $error("start-only pulled read low");
    chk_capture_strobe: assert property (cap_now |->
        !rd_n_o && !cs_n_o) else $error("capture without read strobes");
    chk_acq_gap: assert property (state == sac_pkg::ST_IDLE &&
        next_state == sac_pkg::ST_CONV |-> gap_cnt >= sac_pkg::ACQ_CYC)
        else $error("acquisition gap too short");
    // 14th clock rise comes 27 half periods after release, then acquisition
    chk_power_up: assert property ($rose(ready) |-> since_rst >=
        9'((2 * 13 + 1) * sac_pkg::CLK_HALF + sac_pkg::ACQ_CYC))
        else $error("ready before power-up wait");
    chk_slow_wait: assert property (mode == sac_pkg::MODE_SLOW &&
        state == sac_pkg::ST_CONV |-> !convert_start_n_o && !rd_n_o &&
        !cs_n_o) else $error("slow-memory strobes released early");
    chk_rom_space: assert property (mode == sac_pkg::MODE_ROM &&
        $rose(rd_n_o) |=> rd_n_o[*8]) else $error("ROM reads too close");
    chk_cont_low: assert property (state == sac_pkg::ST_CONT |->
        !convert_start_n_o && !rd_n_o && !cs_n_o)
        else $error("continuous strobes not low");

    cov_full_both: cover property (state == sac_pkg::ST_CONV && rd_flag);
    cov_rom_read: cover property (mode == sac_pkg::MODE_ROM && cap_now);
    cov_cont_cap: cover property (state == sac_pkg::ST_CONT && cap_now);
    cov_slow_end: cover property (mode == sac_pkg::MODE_SLOW && cap_now);
endmodule : sac_ctrl
`default_nettype wire

/* File: dv/sac_adc_model.sv */
/*
 * Behavioural model of the 12-bit converter with a parallel result bus.
 * Assumes the controller drives its clock and strobes; sample_i is the
 * value the next conversion returns, strap inputs come from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_adc_model (
    input wire logic conv_clk_i,
    input wire logic convert_start_n_i,
    input wire logic rd_n_i,
    input wire logic cs_n_i,
    input wire logic int_mode_i,
    input wire logic cont_i,
    input wire logic [11:0] sample_i,
    output logic status_n_o,
    output logic [11:0] result_bus_o
);
    logic busy = 1'b0;
    logic irq = 1'b0;
    logic [11:0] held = 12'h000;
    int cnt = 0;
    int len = 13;
    int last_len = 0;
    int nconv = 0;
    int pw = 0;
    int acq_err = 0;
    realtime t_go = 0.0;
    // unset until tracking begins, so an early start counts as too soon
    realtime t_end = 1.0e9;
    wire logic rd_sel;
    assign rd_sel = !rd_n_i && !cs_n_i;
    always @(negedge convert_start_n_i or posedge rd_sel) begin
        if (!convert_start_n_i && !busy) begin
            if ($realtime - t_end < 350.0)
                acq_err++;
            busy = 1'b1;
            cnt = 0;
            t_go = $realtime;
        end
    end
    always @(negedge rd_sel) irq = 1'b0;
    always @(posedge conv_clk_i) begin
        if (pw < 14) begin
            pw++;
            if (pw == 14)
                t_end = $realtime;
        end
        if (busy) begin
            if (cnt == 0)
                len = ($realtime - t_go >= 50.0) ? 13 : 14;
            cnt++;
            if (cnt == len) begin
                busy = 1'b0;
                held = sample_i;
                last_len = len;
                nconv++;
                irq = int_mode_i;
                t_end = $realtime;
            end
        end else if (cont_i && rd_sel && !convert_start_n_i) begin
            busy = 1'b1;
            cnt = 0;
            t_go = $realtime;
        end
    end
    assign status_n_o = int_mode_i ? !irq : !busy;
    // released bus shows the inverse, never a stale copy
    assign result_bus_o = rd_sel ? held : ~held;
endmodule : sac_adc_model
`default_nettype wire

/* File: dv/testbench.sv */
/*
 * Self-checking bench: APB scenarios per converter mode against the model.
 * Assumes sac_pkg, sac_ctrl and sac_adc_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, slverr, cclk, cst_n, rd_n, cs_n, stat_n;
    logic int_mode = 1'b0, cont = 1'b0;
    logic [11:0] sample = 12'h000, bus, s, prev;
    int err_count = 0;
    int total_checks = 0;
    int n0;
    always #10 clk_sys_i = ~clk_sys_i;
    sac_ctrl i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(pslverr),
        .prdata_o(prdata), .conv_clk_o(cclk), .convert_start_n_o(cst_n),
        .rd_n_o(rd_n), .cs_n_o(cs_n), .status_n_i(stat_n),
        .result_bus_i(bus));
    sac_adc_model i_adc (.conv_clk_i(cclk), .convert_start_n_i(cst_n),
        .rd_n_i(rd_n), .cs_n_i(cs_n), .int_mode_i(int_mode), .cont_i(cont),
        .sample_i(sample), .status_n_o(stat_n), .result_bus_o(bus));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            err_count++;
        r = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // a command waits up to one conversion clock period for its clock fall;
    // poll only after that, then wait for idle
    task automatic cmd(input logic [31:0] c);
        int n;
        n = 0;
        wr(sac_pkg::REG_CMD, c);
        repeat (12) @(posedge clk_sys_i);
        do begin
            rd(sac_pkg::REG_STATUS);
            n++;
        end while (r[0] !== 1'b0 && n < 300);
        if (r[0] !== 1'b0)
            err_count++;
    endtask : cmd
    task automatic t_regs();
        rd(sac_pkg::REG_CTRL);
        chk(r, 32'h0000_0000);
        rd(8'h10);
        chk({r[30:0], slverr}, 32'h0000_0001);
        chk({29'h0, cst_n, rd_n, cs_n}, 32'h0000_0007);
    endtask : t_regs
    task automatic t_full();
        sample <= 12'hA5C;
        n0 = i_adc.nconv;
        cmd(32'h1);
        chk(i_adc.nconv - n0, 1);
        chk(i_adc.last_len, 13);
        sample <= 12'h3C1;
        cmd(32'h2);
        chk(i_adc.nconv - n0, 1);
        rd(sac_pkg::REG_RESULT);
        chk(r, 32'h0000_0A5C);
        cmd(32'h3);
        chk(i_adc.nconv - n0, 2);
        rd(sac_pkg::REG_RESULT);
        chk(r, 32'h0000_0A5C);
        cmd(32'h2);
        rd(sac_pkg::REG_RESULT);
        chk(r, 32'h0000_03C1);
        prev = 12'h3C1;
    endtask : t_full
    task automatic t_irq();
        int_mode <= 1'b1;
        wr(sac_pkg::REG_CTRL, 32'h8);
        cmd(32'h1);
        rd(sac_pkg::REG_STATUS);
        chk(r[3], 1'b0);
        cmd(32'h2);
        rd(sac_pkg::REG_STATUS);
        chk(r[3], 1'b1);
        int_mode <= 1'b0;
    endtask : t_irq
    // stand-alone and slow-memory return the new value, ROM the old one
    task automatic t_modes();
        for (int m = 1; m <= 3; m++) begin
            wr(sac_pkg::REG_CTRL, 32'(m));
            s = {4'(m), 8'h5A};
            sample <= s;
            cmd(m == 1 ? 32'h1 : 32'h2);
            rd(sac_pkg::REG_RESULT);
            chk(r, {20'h0, m == 3 ? prev : s});
            prev = s;
        end
        cmd(32'h2);
        rd(sac_pkg::REG_RESULT);
        chk(r, {20'h0, s});
    endtask : t_modes
    task automatic t_cont();
        cont <= 1'b1;
        sample <= 12'h7FF;
        wr(sac_pkg::REG_CTRL, 32'h14);
        repeat (400) @(posedge clk_sys_i);
        n0 = i_adc.nconv;
        sample <= 12'h801;
        repeat (1400) @(posedge clk_sys_i);
        chk(i_adc.nconv - n0, 10);
        rd(sac_pkg::REG_RESULT);
        chk(r, 32'h0000_0801);
        wr(sac_pkg::REG_CTRL, 32'h4);
        repeat (300) @(posedge clk_sys_i);
        chk({29'h0, cst_n, rd_n, cs_n}, 32'h0000_0007);
        n0 = i_adc.nconv;
        repeat (300) @(posedge clk_sys_i);
        chk(i_adc.nconv - n0, 0);
        cont <= 1'b0;
        chk(i_adc.acq_err, 0);
    endtask : t_cont
    task automatic print_verdict();
        $display("checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        n0 = 0;
        do begin
            rd(sac_pkg::REG_STATUS);
            n0++;
        end while (r[1] !== 1'b1 && n0 < 200);
        if (r[1] !== 1'b1)
            err_count++;
        t_regs();
        t_full();
        t_irq();
        t_modes();
        t_cont();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
